/* rtl/dpc_pkg.sv */
// shared constants and types for the discrete point conditioner
package dpc_pkg;

    // point counts
    localparam int NUM_IN = 8; // discrete inputs per module
    localparam int NUM_OUT = 8; // discrete outputs per module

    // clock rate
    localparam int unsigned CLK_HZ = 20_000_000;

    // time base: one sample and timing tick per millisecond
    localparam int unsigned SAMPLE_PERIOD_US = 1000;
    localparam int unsigned SAMPLE_CYC = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
    // seconds tick for chatter periods
    localparam int unsigned SECOND_S = 1;
    localparam int unsigned SECOND_CYC = SECOND_S * CLK_HZ;

    // blink half period counted in sample ticks
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam logic [9:0] BLINK_HALF_TICKS = 10'(BLINK_HALF_MS * 1000 / SAMPLE_PERIOD_US);

    // chatter periods counted in seconds ticks
    localparam logic [6:0] CHAT_PER_1S = 7'h01;
    localparam logic [6:0] CHAT_PER_10S = 7'h0A;
    localparam logic [6:0] CHAT_PER_100S = 7'h64;

    // filter selector codes and sample counts
    localparam logic [1:0] FILT_SEL_0 = 2'h0;
    localparam logic [1:0] FILT_SEL_1 = 2'h1;
    localparam logic [1:0] FILT_SEL_2 = 2'h2;
    localparam logic [1:0] FILT_SEL_4 = 2'h3;

    // chatter period selector codes
    localparam logic [1:0] PER_SEL_1S = 2'h0;
    localparam logic [1:0] PER_SEL_10S = 2'h1;
    localparam logic [1:0] PER_SEL_100S = 2'h2;

    // output drive styles, code 3 behaves as normal
    localparam logic [1:0] STYLE_NORMAL = 2'h0;
    localparam logic [1:0] STYLE_BLINK = 2'h1;
    localparam logic [1:0] STYLE_PULSE_DELAY = 2'h2;

    // chatter counter reset value and ceiling
    localparam logic [7:0] CHAT_CNT_RST = 8'h00;
    localparam logic [7:0] CHAT_CNT_MAX = 8'hFF;

    // output point state
    typedef enum logic [2:0] {
        DPC_PT_IDLE = 3'b001,
        DPC_PT_WAIT = 3'b010,
        DPC_PT_ACT = 3'b100
    } dpc_pt_state_t;

    // output point register set
    typedef struct packed {
        dpc_pt_state_t state;
        logic [15:0] timer;
        logic cmd_prev;
        logic drive;
    } dpc_pt_st_t;

    // input side and time base register set
    typedef struct packed {
        logic [NUM_IN-1:0][2:0] agree_cnt;
        logic [NUM_IN-1:0] filt;
        logic [NUM_IN-1:0][7:0] trans_cnt;
        logic [NUM_IN-1:0] flag;
        logic [15:0] ms_pre;
        logic [24:0] sec_pre;
        logic [6:0] per_cnt;
        logic [9:0] blink_cnt;
        logic blink_phase;
    } dpc_main_st_t;

endpackage : dpc_pkg

/* rtl/dpc_out_if.sv */
// carrier between the conditioner core and one output point
`timescale 1ns/1ps
interface dpc_out_if;
    logic cmd; // commanded state from cpu
    logic [1:0] style; // output_drive_style of this point
    logic pulse_sel; // 1 pulse, 0 delay
    logic pol_neg; // 1 falling edge trigger
    logic early_end; // early_pulse_end_enable
    logic [15:0] duration; // pulse or delay length in ms ticks
    logic ms_tick; // time base tick
    logic blink_phase; // shared blink phase
    logic drive; // conditioned output level

    // core side
    modport ctl (
        output cmd, style, pulse_sel, pol_neg, early_end, duration, ms_tick, blink_phase,
        input drive
    );
    // point side
    modport pt (
        input cmd, style, pulse_sel, pol_neg, early_end, duration, ms_tick, blink_phase,
        output drive
    );
endinterface : dpc_out_if

/* rtl/dpc_out_point.sv */
// one discrete output point: normal, blinking and pulse/delay drive
`timescale 1ns/1ps
module dpc_out_point (
    input wire logic ref_clk,
    input wire logic reset_n,
    dpc_out_if.pt bus
);

    dpc_pkg::dpc_pt_st_t st_reg; // registered state
    dpc_pkg::dpc_pt_st_t st_next; // next state
    logic act_lvl; // level the output moves to on trigger
    logic trig; // triggering edge of commanded state
    logic at_rest; // commanded state back at original level
    logic time_up; // duration reached on this tick

    // next state of the point
    always_comb
    begin
        st_next = st_reg;
        act_lvl = ~bus.pol_neg; // R09
        at_rest = (bus.cmd == bus.pol_neg);
        trig = (bus.cmd == act_lvl) && (st_reg.cmd_prev != act_lvl); // R09
        time_up = bus.ms_tick && ((st_reg.timer + 16'h0001) >= bus.duration);
        st_next.cmd_prev = bus.cmd;
        case (bus.style)
            // blinked output follows the shared phase while commanded on
            dpc_pkg::STYLE_BLINK:
            begin
                st_next.state = dpc_pkg::DPC_PT_IDLE;
                st_next.timer = 16'h0000;
                st_next.drive = bus.cmd & bus.blink_phase; // R06
            end
            // pulse or delayed transition
            dpc_pkg::STYLE_PULSE_DELAY:
            begin
                case (st_reg.state)
                    // waiting for the triggering edge
                    dpc_pkg::DPC_PT_IDLE:
                    begin
                        st_next.drive = bus.pol_neg;
                        st_next.timer = 16'h0000;
                        if (trig && bus.pulse_sel)
                        begin
                            st_next.state = dpc_pkg::DPC_PT_ACT; // R08
                            st_next.drive = act_lvl; // R08
                        end
                        else if (trig)
                        begin
                            st_next.state = dpc_pkg::DPC_PT_WAIT; // R07
                        end
                    end
                    // delay running before the copied transition
                    dpc_pkg::DPC_PT_WAIT:
                    begin
                        if (at_rest)
                        begin
                            st_next.state = dpc_pkg::DPC_PT_IDLE; // R07
                            st_next.drive = bus.pol_neg;
                        end
                        else if (time_up)
                        begin
                            st_next.state = dpc_pkg::DPC_PT_ACT; // R07
                            st_next.drive = act_lvl;
                            st_next.timer = 16'h0000;
                        end
                        else if (bus.ms_tick)
                        begin
                            st_next.timer = st_reg.timer + 16'h0001;
                        end
                    end
                    // output at active level
                    dpc_pkg::DPC_PT_ACT:
                    begin
                        if (!bus.pulse_sel)
                        begin
                            // delayed copy returns with the command
                            if (at_rest)
                            begin
                                st_next.state = dpc_pkg::DPC_PT_IDLE; // R07
                                st_next.drive = bus.pol_neg;
                            end
                        end
                        else if (bus.early_end && at_rest)
                        begin
                            st_next.state = dpc_pkg::DPC_PT_IDLE; // R10
                            st_next.drive = bus.pol_neg;
                        end
                        else if (time_up)
                        begin
                            // full duration ends the pulse
                            st_next.state = dpc_pkg::DPC_PT_IDLE; // R11
                            st_next.drive = bus.pol_neg;
                            st_next.timer = 16'h0000;
                        end
                        else if (bus.ms_tick)
                        begin
                            st_next.timer = st_reg.timer + 16'h0001; // R11
                        end
                    end
                    // illegal code falls back to idle
                    default:
                    begin
                        st_next.state = dpc_pkg::DPC_PT_IDLE;
                        st_next.drive = bus.pol_neg;
                    end
                endcase
            end
            // normal drive follows the command directly
            default:
            begin
                st_next.state = dpc_pkg::DPC_PT_IDLE;
                st_next.timer = 16'h0000;
                st_next.drive = bus.cmd; // R13
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_reg <= '{state: dpc_pkg::DPC_PT_IDLE, timer: 16'h0000, cmd_prev: 1'b0,
                        drive: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign bus.drive = st_reg.drive;

    default clocking pt_cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // a pulse that may not end early
    sequence pulse_live_s;
        bus.style == dpc_pkg::STYLE_PULSE_DELAY && bus.pulse_sel && !bus.early_end &&
            st_reg.state == dpc_pkg::DPC_PT_ACT && !bus.ms_tick;
    endsequence

    normal_pass_a: assert property (bus.style == dpc_pkg::STYLE_NORMAL |=> // R13
        bus.drive == $past(bus.cmd)) else $error("normal output not following command");
    blink_low_a: assert property (bus.style == dpc_pkg::STYLE_BLINK && !bus.cmd |=> // R06
        !bus.drive) else $error("blinked output on while commanded off");
    pulse_start_a: assert property (bus.style == dpc_pkg::STYLE_PULSE_DELAY && // R08
        bus.pulse_sel && st_reg.state == dpc_pkg::DPC_PT_IDLE && trig |=>
        bus.drive == !$past(bus.pol_neg)) else $error("pulse did not start on edge");
    early_end_a: assert property (bus.style == dpc_pkg::STYLE_PULSE_DELAY && // R10
        bus.pulse_sel && bus.early_end && st_reg.state == dpc_pkg::DPC_PT_ACT && at_rest
        |=> bus.drive == $past(bus.pol_neg)) else $error("pulse did not end early");
    pulse_hold_a: assert property (pulse_live_s |=> bus.drive == $past(bus.drive)) // R11
        else $error("pulse ended before its duration");
    delay_drop_a: assert property (bus.style == dpc_pkg::STYLE_PULSE_DELAY && // R07
        !bus.pulse_sel && st_reg.state != dpc_pkg::DPC_PT_IDLE && at_rest |=>
        bus.drive == $past(bus.pol_neg) && st_reg.state == dpc_pkg::DPC_PT_IDLE)
        else $error("delayed output not restored");
    edge_dir_a: assert property (bus.style == dpc_pkg::STYLE_PULSE_DELAY && // R09
        st_reg.state == dpc_pkg::DPC_PT_IDLE ##1 st_reg.state == dpc_pkg::DPC_PT_IDLE
        |-> bus.drive == $past(bus.pol_neg)) else $error("idle level not the rest level");

endmodule : dpc_out_point

/* rtl/dpc_conditioner.sv */
// discrete point conditioner: input filter, chatter detect, output drive styles
//
// Contract
// R01 - accept input after N equal samples
// R02 - chatter detection uses filtered values
// R03 - flag input changing more than limit
// R04 - limit 1 to 255, only when enabled; the transition count stops at 255, so a limit of 255 never raises a flag
// R05 - period 1, 10, 100 s when enabled
// R06 - blink timed by syncable internal clock
// R07 - delay copies edge, restores on return
// R08 - pulse of set duration on edge
// R09 - polarity picks trigger edge and direction
// R10 - early end: pulse stops on return
// R11 - no early end: full duration pulse
// R12 - filter zero passes inputs directly
// R13 - normal mode drives commanded state directly
`timescale 1ns/1ps
module dpc_conditioner #(
    parameter logic [15:0] SAMPLE_CYC = 16'(dpc_pkg::SAMPLE_CYC),
    parameter logic [24:0] SECOND_CYC = 25'(dpc_pkg::SECOND_CYC)
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic net_sync,
    input wire logic [dpc_pkg::NUM_IN-1:0] raw_in,
    input wire logic [1:0] filter_sel,
    input wire logic chatter_enable,
    input wire logic [7:0] chatter_limit,
    input wire logic [1:0] chatter_period_sel,
    input wire logic [dpc_pkg::NUM_IN-1:0] chatter_flag_clear,
    output logic [dpc_pkg::NUM_IN-1:0] filtered_in,
    output logic [dpc_pkg::NUM_IN-1:0] chatter_flags,
    input wire logic [dpc_pkg::NUM_OUT-1:0] cmd_out,
    input wire logic [2*dpc_pkg::NUM_OUT-1:0] output_drive_style,
    input wire logic [dpc_pkg::NUM_OUT-1:0] pd_pulse_select,
    input wire logic [dpc_pkg::NUM_OUT-1:0] pd_polarity_neg,
    input wire logic [dpc_pkg::NUM_OUT-1:0] early_pulse_end_enable,
    input wire logic [15:0] pd_duration,
    output logic [dpc_pkg::NUM_OUT-1:0] point_out
);

    dpc_pkg::dpc_main_st_t st_reg; // registered state
    dpc_pkg::dpc_main_st_t st_next; // next state
    logic ms_tick; // sample and timing tick
    logic sec_tick; // one second tick
    logic period_end; // end of chatter period
    logic [2:0] need_cnt; // samples needed to accept a change
    logic [6:0] per_len; // chatter period in seconds
    logic [7:0] eff_limit; // chatter limit, zero read as one

    // samples needed for a selector code
    function automatic logic [2:0] samples_needed(input logic [1:0] sel);
        case (sel)
            dpc_pkg::FILT_SEL_1: samples_needed = 3'h1;
            dpc_pkg::FILT_SEL_2: samples_needed = 3'h2;
            dpc_pkg::FILT_SEL_4: samples_needed = 3'h4;
            default: samples_needed = 3'h0;
        endcase
    endfunction : samples_needed

    // chatter period length for a selector code
    function automatic logic [6:0] period_seconds(input logic [1:0] sel);
        case (sel)
            dpc_pkg::PER_SEL_10S: period_seconds = dpc_pkg::CHAT_PER_10S;
            dpc_pkg::PER_SEL_100S: period_seconds = dpc_pkg::CHAT_PER_100S;
            default: period_seconds = dpc_pkg::CHAT_PER_1S;
        endcase
    endfunction : period_seconds

    // time base, input filter and chatter counting
    always_comb
    begin
        st_next = st_reg;
        ms_tick = 1'b0;
        sec_tick = 1'b0;
        period_end = 1'b0;
        need_cnt = samples_needed(filter_sel);
        per_len = period_seconds(chatter_period_sel); // R05
        eff_limit = (chatter_limit == 8'h00) ? 8'h01 : chatter_limit; // R04
        // network sync realigns the internal clock
        if (net_sync)
        begin
            st_next.ms_pre = 16'h0000; // R06
            st_next.sec_pre = 25'h0000000;
            st_next.blink_cnt = 10'h000;
            st_next.blink_phase = 1'b0;
        end
        else
        begin
            // millisecond prescaler
            if (st_reg.ms_pre >= SAMPLE_CYC - 16'h0001)
            begin
                st_next.ms_pre = 16'h0000;
                ms_tick = 1'b1;
            end
            else
            begin
                st_next.ms_pre = st_reg.ms_pre + 16'h0001;
            end
            // seconds prescaler
            if (st_reg.sec_pre >= SECOND_CYC - 25'h0000001)
            begin
                st_next.sec_pre = 25'h0000000;
                sec_tick = 1'b1;
            end
            else
            begin
                st_next.sec_pre = st_reg.sec_pre + 25'h0000001;
            end
            // blink phase toggles every half period
            if (ms_tick)
            begin
                if (st_reg.blink_cnt >= dpc_pkg::BLINK_HALF_TICKS - 10'h001)
                begin
                    st_next.blink_cnt = 10'h000; // R06
                    st_next.blink_phase = ~st_reg.blink_phase;
                end
                else
                begin
                    st_next.blink_cnt = st_reg.blink_cnt + 10'h001;
                end
            end
        end
        // chatter period counter runs only while detection is on
        if (!chatter_enable)
        begin
            st_next.per_cnt = 7'h00; // R05
        end
        else if (sec_tick)
        begin
            if (st_reg.per_cnt >= per_len - 7'h01)
            begin
                st_next.per_cnt = 7'h00; // R05
                period_end = 1'b1;
            end
            else
            begin
                st_next.per_cnt = st_reg.per_cnt + 7'h01;
            end
        end
        for (int i = 0; i < dpc_pkg::NUM_IN; i++)
        begin
            // debounce filter
            if (filter_sel == dpc_pkg::FILT_SEL_0)
            begin
                st_next.filt[i] = raw_in[i]; // R12
                st_next.agree_cnt[i] = 3'h0;
            end
            else if (ms_tick)
            begin
                if (raw_in[i] == st_reg.filt[i])
                begin
                    st_next.agree_cnt[i] = 3'h0; // R01
                end
                else if ((st_reg.agree_cnt[i] + 3'h1) >= need_cnt)
                begin
                    st_next.filt[i] = raw_in[i]; // R01
                    st_next.agree_cnt[i] = 3'h0;
                end
                else
                begin
                    st_next.agree_cnt[i] = st_reg.agree_cnt[i] + 3'h1; // R01
                end
            end
            // chatter counting on filtered transitions
            if (!chatter_enable)
            begin
                st_next.trans_cnt[i] = dpc_pkg::CHAT_CNT_RST; // R04
                st_next.flag[i] = 1'b0;
            end
            else
            begin
                if (period_end)
                begin
                    st_next.trans_cnt[i] = {7'h00, st_next.filt[i] != st_reg.filt[i]}; // R02
                end
                else if (st_next.filt[i] != st_reg.filt[i] &&
                         st_reg.trans_cnt[i] != dpc_pkg::CHAT_CNT_MAX)
                begin
                    st_next.trans_cnt[i] = st_reg.trans_cnt[i] + 8'h01; // R02
                end
                // set wins over a clear in the same cycle
                st_next.flag[i] = (st_reg.flag[i] & ~chatter_flag_clear[i]) |
                                  (st_next.trans_cnt[i] > eff_limit); // R03
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign filtered_in = st_reg.filt;
    assign chatter_flags = st_reg.flag;

    // one driver per output point
    generate
        for (genvar g = 0; g < dpc_pkg::NUM_OUT; g++)
        begin : g_pt
            dpc_out_if u_if ();
            assign u_if.cmd = cmd_out[g];
            assign u_if.style = output_drive_style[2*g +: 2];
            assign u_if.pulse_sel = pd_pulse_select[g];
            assign u_if.pol_neg = pd_polarity_neg[g];
            assign u_if.early_end = early_pulse_end_enable[g];
            assign u_if.duration = pd_duration;
            assign u_if.ms_tick = ms_tick;
            assign u_if.blink_phase = st_reg.blink_phase;
            assign point_out[g] = u_if.drive;
            dpc_out_point u_pt (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .bus(u_if.pt)
            );
        end
    endgenerate

    default clocking cn_cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    filt_pass_a: assert property (filter_sel == dpc_pkg::FILT_SEL_0 |=> // R12
        filtered_in == $past(raw_in)) else $error("zero filter not passing inputs");
    filt_hold_a: assert property (filter_sel == dpc_pkg::FILT_SEL_2 && ms_tick && // R01
        raw_in[0] != filtered_in[0] && st_reg.agree_cnt[0] == 3'h0 |=>
        $stable(filtered_in[0])) else $error("input accepted after one sample");
    chat_off_a: assert property (!chatter_enable |=> chatter_flags == '0 && // R04 R05
        st_reg.per_cnt == 7'h00) else $error("chatter active while disabled");
    chat_flag_a: assert property (chatter_enable && st_reg.trans_cnt[0] > eff_limit |-> // R03
        chatter_flags[0]) else $error("chattering input not flagged");
    chat_src_a: assert property (chatter_enable && !period_end && // R02
        st_next.filt[0] == st_reg.filt[0] |=> $stable(st_reg.trans_cnt[0]))
        else $error("chatter counted without filtered change");
    sync_align_a: assert property (net_sync |=> st_reg.ms_pre == 16'h0000 && // R06
        st_reg.blink_cnt == 10'h000 && !st_reg.blink_phase)
        else $error("time base not realigned by sync");

endmodule : dpc_conditioner

/* test/dpc_cpu_model.sv */
// cpu stand-in that commands the output points and clears chatter flags
`timescale 1ns/1ps
module dpc_cpu_model (
    input wire logic ref_clk,
    output logic [7:0] cmd_out,
    output logic [7:0] flag_clear
);
    // falling-edge point starts at its rest level
    initial cmd_out = 8'h20;
    // no clear request at start
    initial flag_clear = 8'h00;

    // new command just after an edge, held until the next command
    task automatic set_cmd(input logic [7:0] v);
        @(posedge ref_clk);
        cmd_out <= v;
    endtask : set_cmd

    // one-cycle clear request for the masked flags
    task automatic clear(input logic [7:0] m);
        @(posedge ref_clk);
        flag_clear <= m;
        @(posedge ref_clk);
        flag_clear <= 8'h00;
    endtask : clear
endmodule : dpc_cpu_model

/* test/tb_discrete_point_conditioner.sv */
// self-checking bench for the discrete point conditioner
`timescale 1ns/1ps
module tb_discrete_point_conditioner;
    localparam int SC = 10; // shortened sample period in cycles
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic net_sync = 1'b0;
    logic [7:0] raw_in = 8'h00;
    logic [1:0] filter_sel = 2'h0;
    logic chatter_enable = 1'b0;
    logic [7:0] chatter_limit = 8'h03;
    logic [1:0] chatter_period_sel = 2'h0;
    logic [15:0] drive_style = 16'h3AA4, duration = 16'h0004; // point styles, pulse length
    logic [7:0] pulse_sel = 8'h2C, pol_neg = 8'h20, early_end = 8'h04; // pulse/delay setup
    logic [7:0] flag_clear, cmd_out, filtered_in, chatter_flags, point_out;
    logic [7:0] v;
    logic [7:0] old = 8'h00; // modelled accepted input level
    int seed = 19393;
    int tests_run = 0;
    int bad_count = 0;
    int nsamp[$] = '{1, 2, 4}; // samples needed per filter code 1..3

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    // cpu side of the outputs
    dpc_cpu_model cpu (.ref_clk(ref_clk), .cmd_out(cmd_out), .flag_clear(flag_clear));

    // styles: p0 normal, p1 blink, p2..p5 pulse/delay, p6 code 3, p7 normal
    dpc_conditioner #(.SAMPLE_CYC(16'h000A), .SECOND_CYC(25'h0000064)) uut (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .net_sync(net_sync),
        .raw_in(raw_in),
        .filter_sel(filter_sel),
        .chatter_enable(chatter_enable),
        .chatter_limit(chatter_limit),
        .chatter_period_sel(chatter_period_sel),
        .chatter_flag_clear(flag_clear),
        .filtered_in(filtered_in),
        .chatter_flags(chatter_flags),
        .cmd_out(cmd_out),
        .output_drive_style(drive_style),
        .pd_pulse_select(pulse_sel),
        .pd_polarity_neg(pol_neg),
        .early_pulse_end_enable(early_end),
        .pd_duration(duration),
        .point_out(point_out)
    );

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // counts, verdict and end of run
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // let n edges pass, then look once their updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // flip every raw input n times, two cycles apart
    task automatic toggle(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            raw_in <= ~raw_in;
            @(posedge ref_clk);
        end
        tick(2);
    endtask : toggle

    // one-cycle time sync realigns ticks and blink phase
    task automatic sync;
        @(posedge ref_clk);
        net_sync <= 1'b1;
        @(posedge ref_clk);
        net_sync <= 1'b0;
    endtask : sync

    // hang guard
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        tick(2);
        check(point_out, 8'h20);
        // normal points follow random commands one cycle later
        repeat (8)
        begin
            v = 8'($random(seed));
            cpu.set_cmd((v & 8'hC1) | 8'h20);
            tick(1);
            check(point_out & 8'hE1, (v & 8'hC1) | 8'h20);
        end
        // every filter code, ticks aligned by a sync
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($random(seed));
            @(posedge ref_clk);
            filter_sel <= 2'(i);
            raw_in <= v;
            net_sync <= 1'b1;
            @(posedge ref_clk);
            net_sync <= 1'b0;
            #1;
            if (i == 0)
                check(filtered_in, v);
            else
            begin
                tick(nsamp[i-1] * SC - 3);
                check(filtered_in, old);
                tick(6);
                check(filtered_in, v);
            end
            old = v;
        end
        // raw chatter that never passes the filter raises no flag
        @(posedge ref_clk);
        filter_sel <= 2'h2;
        chatter_limit <= 8'h01;
        chatter_enable <= 1'b1;
        repeat (12)
        begin
            @(posedge ref_clk);
            raw_in <= ~raw_in;
            repeat (SC - 1) @(posedge ref_clk);
        end
        tick(1);
        check(filtered_in, old);
        check(chatter_flags, 8'h00);
        // each chatter period code: flag above limit; clear holds after a 1 s period end, not inside a 10 or 100 s period
        for (int p = 0; p < 3; p++)
        begin
            @(posedge ref_clk);
            chatter_enable <= 1'b0;
            chatter_period_sel <= 2'(p);
            filter_sel <= 2'h0;
            chatter_limit <= 8'h03;
            @(posedge ref_clk);
            chatter_enable <= 1'b1;
            toggle(3);
            check(chatter_flags, 8'h00);
            toggle(1);
            check(chatter_flags, 8'hFF);
            tick(250);
            cpu.clear(8'h0F);
            tick(1);
            check(chatter_flags, (p == 0) ? 8'hF0 : 8'hFF);
            @(posedge ref_clk);
            chatter_enable <= 1'b0;
            tick(1);
            check(chatter_flags, 8'h00);
            toggle(4);
            check(chatter_flags, 8'h00);
        end
        // pulse, early-end pulse, delay and falling pulse triggered together
        sync();
        cpu.set_cmd(8'h1E);
        tick(1);
        check(point_out & 8'h3E, 8'h0C);
        tick(4);
        cpu.set_cmd(8'h12);
        tick(1);
        check(point_out & 8'h3E, 8'h08);
        tick(16);
        check(point_out & 8'h3E, 8'h08);
        tick(20);
        check(point_out & 8'h3E, 8'h30);
        cpu.set_cmd(8'h02);
        tick(1);
        check(point_out & 8'h3E, 8'h20);
        // blink phase flips after one half period from sync
        sync();
        tick(int'(dpc_pkg::BLINK_HALF_TICKS) * SC - 20);
        check(point_out[1], 1'b0);
        tick(40);
        check(point_out[1], 1'b1);
        cpu.set_cmd(8'h20);
        tick(1);
        check(point_out, 8'h20);
        // second setup: falling delay, rising delay, falling pulse of two ticks, p7 blink
        @(posedge ref_clk);
        drive_style <= 16'h7AA4;
        pulse_sel <= 8'h24;
        pol_neg <= 8'h30;
        early_end <= 8'h08;
        duration <= 16'h0002;
        net_sync <= 1'b1;
        @(posedge ref_clk);
        net_sync <= 1'b0;
        cpu.set_cmd(8'h98);
        tick(1);
        check(point_out & 8'hBC, 8'h10);
        cpu.set_cmd(8'h88);
        tick(1);
        check(point_out & 8'hBC, 8'h10);
        tick(10);
        check(point_out & 8'hBC, 8'h10);
        tick(10);
        check(point_out & 8'hBC, 8'h28);
        // pulse point not retriggered, falling delay restored on return
        cpu.set_cmd(8'h98);
        tick(1);
        check(point_out & 8'hBC, 8'h38);
        give_verdict();
    end
endmodule : tb_discrete_point_conditioner
